/* logic/config_word_decoder.sv */
// Purpose: latch configuration words and decode device settings
// Assumes: words come from nonvolatile store, stable during reset
// Notes: APB reads return stored words; writes only touch soft watchdog
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module config_word_decoder import cfg_word_pkg::*; #(
  parameter bit EIGHT_OUTPUT = 1'b1,
  parameter bit LARGE_MEMORY = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Stored configuration words
  input wire logic [7:0] nv_cfg2h,
  input wire logic [7:0] nv_cfg3l,
  input wire logic [7:0] nv_cfg3h,
  input wire logic [7:0] nv_cfg4l,
  input wire logic [7:0] nv_cfg5l,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events and pins from the core
  input wire logic special_event_reset_enable,
  input wire logic capture_trigger,
  input wire logic stack_fault,
  input wire logic lvp_entry_request,
  input wire logic [7:0] pwm_raw,
  input wire logic [7:0] pwm_fault_state,
  input wire logic [7:0] pwm_override_state,
  input wire logic fault_active,
  input wire logic override_active,
  input wire logic port_c_bit1,
  input wire logic port_c_bit3,
  input wire logic port_d_bit0,
  input wire logic port_d_bit4,
  input wire logic ssp_sck_out,
  input wire logic ssp_sdo_out,
  // Decoded outputs
  output core_ctrl_t core_ctrl,
  output pin_ctrl_t pin_ctrl,
  output logic [7:0] ssp_pin_sel,
  output logic pwm4_on_port_b5,
  output logic timebase_reset_pulse,
  output logic stack_reset_pulse,
  output logic lvp_entry_grant,
  output logic [2:0] port_c_ssp_out,
  output logic [2:0] port_d_ssp_out
);
  logic [7:0] cfg2h;
  logic [7:0] cfg3l;
  logic [7:0] cfg3h;
  logic [7:0] cfg4l;
  logic [7:0] cfg5l;
  logic loaded;
  logic soft_wdt;

  // Capture after release from stored words
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  wire [7:0] mask5 = LARGE_MEMORY ? MASK_CFG5L_LARGE : MASK_CFG5L_SMALL;

  // Word 2 high capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg2h <= 8'h00;
    end else if (!loaded) begin
      cfg2h <= nv_cfg2h & MASK_CFG2H;
    end
  end

  // Word 3 low capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg3l <= 8'h00;
    end else if (!loaded) begin
      cfg3l <= nv_cfg3l & MASK_CFG3L;
    end
  end

  // Word 3 high capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg3h <= 8'h00;
    end else if (!loaded) begin
      cfg3h <= nv_cfg3h & MASK_CFG3H;
    end
  end

  // Word 4 low capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg4l <= 8'h00;
    end else if (!loaded) begin
      cfg4l <= nv_cfg4l & MASK_CFG4L;
    end
  end

  // Word 5 low capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg5l <= 8'h00;
    end else if (!loaded) begin
      cfg5l <= nv_cfg5l & mask5;
    end
  end

  // APB decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_2h = paddr == ADDR_CFG2H;
  wire hit_3l = paddr == ADDR_CFG3L;
  wire hit_3h = paddr == ADDR_CFG3H;
  wire hit_4l = paddr == ADDR_CFG4L;
  wire hit_5l = paddr == ADDR_CFG5L;
  wire hit_st = paddr == ADDR_STATUS;
  wire hit_sw = paddr == ADDR_SWDT;
  wire mapped = hit_2h | hit_3l | hit_3h | hit_4l | hit_5l | hit_st | hit_sw;
  wire [31:0] rd_mux = hit_2h ? {24'h000000, cfg2h} :
                       hit_3l ? {24'h000000, cfg3l} :
                       hit_3h ? {24'h000000, cfg3h} :
                       hit_4l ? {24'h000000, cfg4l} :
                       hit_5l ? {24'h000000, cfg5l} :
                       hit_st ? {30'h0, core_ctrl.watchdog_run, loaded} :
                       hit_sw ? {31'h0, soft_wdt} : RESP_ZERO;
  wire wr_soft = access && pready && pwrite && hit_sw;

  // Ready one cycle after setup
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Error for unmapped offsets
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !mapped;
    end
  end

  // Read data for the access phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= RESP_ZERO;
    end else begin
      prdata <= (setup && !pwrite) ? rd_mux : RESP_ZERO;
    end
  end

  // Soft watchdog enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_wdt <= 1'b0;
    end else if (wr_soft) begin
      soft_wdt <= pwdata[0];
    end
  end

  // Settings decode
  wire win_en = cfg2h[BIT_WATCHDOG_WINDOW_ENABLE];
  wire [3:0] ps_sel = cfg2h[BIT_WDPS_LO +: 4];
  wire [15:0] ps_ratio = 16'h0001 << ps_sel;
  wire wdt_run = cfg2h[BIT_WDT_HARD] | soft_wdt;
  wire tb_gate_open = !cfg3l[BIT_CAP_GATE] && special_event_reset_enable;
  wire odd_pol = cfg3l[BIT_ODD_POL];
  wire even_pol = cfg3l[BIT_EVEN_POL];
  wire pwm_rst_off = cfg3l[BIT_PWM_RST];
  wire rst_pin = cfg3h[BIT_RST_PIN];
  wire clk_mx = cfg3h[BIT_CLK_MX];
  wire pwm4_mx = cfg3h[BIT_PWM4_MX];
  wire ssp_mx = cfg3h[BIT_SSP_MX];
  wire flt_mx = cfg3h[BIT_FAULT_MX];
  wire dbg_off = cfg4l[BIT_BKDBG];
  wire lvp_en = cfg4l[BIT_LVP];
  wire stv_en = cfg4l[BIT_STV];

  // PWM polarity across all sources
  wire [7:0] pwm_src = override_active ? pwm_override_state :
                       fault_active ? pwm_fault_state : pwm_raw;
  wire [7:0] pol_vec;
  wire [7:0] pwm_pol;
  wire [7:0] ch_mask = EIGHT_OUTPUT ? 8'hFF : 8'h3F;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pol
      if (g % 2 == 1) begin : g_odd
        assign pol_vec[g] = odd_pol;
      end else begin : g_even
        assign pol_vec[g] = even_pol;
      end
      assign pwm_pol[g] = (pwm_src[g] ~^ pol_vec[g]) ? 1'b1 : 1'b0;
    end
  endgenerate
  wire [2:0] pwm_en_init = pwm_rst_off ? PWM_EN_OFF :
                           (EIGHT_OUTPUT ? PWM_EN_EIGHT : PWM_EN_SIX);
  wire [7:0] pwm_out = pwm_pol & ch_mask;

  wire [7:0] ssp_sel_vec = ssp_mx ? 8'hB0 : 8'h0E;

  core_ctrl_t next_core;
  pin_ctrl_t next_pin;
  always_comb begin
    next_core.window_enable = win_en;
    next_core.postscale_ratio = ps_ratio;
    next_core.watchdog_run = wdt_run;
    next_core.timebase_reset = tb_gate_open;
    next_core.master_reset_active = rst_pin;
    next_core.port_e_bit3_input_en = !rst_pin;
    next_core.debug_pins_owned = !dbg_off;
    next_core.low_volt_prog_allowed = lvp_en;
    next_core.stack_reset = stv_en;
    next_pin.pwm_pins = pwm_out;
    next_pin.pwm_output_enable_field = pwm_en_init;
    next_pin.timer_ext_clock_in = clk_mx ? port_c_bit3 : port_d_bit0;
    next_pin.fault_a_input = flt_mx ? port_c_bit1 : port_d_bit4;
    next_pin.block_protected = ~cfg5l[3:0] & mask5[3:0];
  end

  // Core settings register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_ctrl <= '0;
    end else begin
      core_ctrl <= next_core;
    end
  end

  // Pin settings register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_ctrl <= '0;
    end else begin
      pin_ctrl <= next_pin;
    end
  end

  // Serial pin selection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ssp_pin_sel <= 8'h00;
    end else begin
      ssp_pin_sel <= ssp_sel_vec;
    end
  end

  // Fourth PWM pin selection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm4_on_port_b5 <= 1'b0;
    end else begin
      pwm4_on_port_b5 <= pwm4_mx;
    end
  end

  // Timebase reset pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timebase_reset_pulse <= 1'b0;
    end else begin
      timebase_reset_pulse <= loaded && tb_gate_open && capture_trigger;
    end
  end

  // Stack error reset pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_reset_pulse <= 1'b0;
    end else begin
      stack_reset_pulse <= loaded && stv_en && stack_fault;
    end
  end

  // Low-voltage programming grant
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lvp_entry_grant <= 1'b0;
    end else begin
      lvp_entry_grant <= loaded && lvp_en && lvp_entry_request;
    end
  end

  // Serial outputs on port C
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_c_ssp_out <= 3'h0;
    end else begin
      port_c_ssp_out <= ssp_mx ? {ssp_sdo_out, ssp_sck_out, 1'b0} : 3'h0;
    end
  end

  // Serial outputs on port D
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_d_ssp_out <= 3'h0;
    end else begin
      port_d_ssp_out <= ssp_mx ? 3'h0 : {ssp_sck_out, 1'b0, ssp_sdo_out};
    end
  end
endmodule

/* logic/cfg_word_pkg.sv */
// Purpose: constants and types for the configuration word decoder
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: bit positions follow the stored configuration bytes
package cfg_word_pkg;
  localparam logic [11:0] ADDR_CFG2H = 12'h000;
  localparam logic [11:0] ADDR_CFG3L = 12'h004;
  localparam logic [11:0] ADDR_CFG3H = 12'h008;
  localparam logic [11:0] ADDR_CFG4L = 12'h00C;
  localparam logic [11:0] ADDR_CFG5L = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_SWDT = 12'h018;
  localparam logic [7:0] MASK_CFG2H = 8'h3F;
  localparam logic [7:0] MASK_CFG3L = 8'h3C;
  localparam logic [7:0] MASK_CFG3H = 8'h9D;
  localparam logic [7:0] MASK_CFG4L = 8'h85;
  localparam logic [7:0] MASK_CFG5L_SMALL = 8'h03;
  localparam logic [7:0] MASK_CFG5L_LARGE = 8'h0F;
  localparam int BIT_WDT_HARD = 0;
  localparam int BIT_WDPS_LO = 1;
  localparam int BIT_WATCHDOG_WINDOW_ENABLE = 5;
  localparam int BIT_PWM_RST = 2;
  localparam int BIT_EVEN_POL = 3;
  localparam int BIT_ODD_POL = 4;
  localparam int BIT_CAP_GATE = 5;
  localparam int BIT_FAULT_MX = 0;
  localparam int BIT_SSP_MX = 2;
  localparam int BIT_PWM4_MX = 3;
  localparam int BIT_CLK_MX = 4;
  localparam int BIT_RST_PIN = 7;
  localparam int BIT_STV = 0;
  localparam int BIT_LVP = 2;
  localparam int BIT_BKDBG = 7;
  localparam logic [2:0] PWM_EN_EIGHT = 3'h5;
  localparam logic [2:0] PWM_EN_SIX = 3'h4;
  localparam logic [2:0] PWM_EN_OFF = 3'h0;
  localparam logic [31:0] RESP_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic window_enable;
    logic [15:0] postscale_ratio;
    logic watchdog_run;
    logic timebase_reset;
    logic master_reset_active;
    logic port_e_bit3_input_en;
    logic debug_pins_owned;
    logic low_volt_prog_allowed;
    logic stack_reset;
  } core_ctrl_t;

  typedef struct packed {
    logic [7:0] pwm_pins;
    logic [2:0] pwm_output_enable_field;
    logic timer_ext_clock_in;
    logic fault_a_input;
    logic [3:0] block_protected;
  } pin_ctrl_t;
endpackage

/* tb/config_word_checker.sv */
// Purpose: port assertions for the configuration word decoder
// Assumes: config words stable while reset is low
// Notes: config copies latched beside the design
`timescale 1ns/1ns
module config_word_checker import cfg_word_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Stored words
  input wire logic [7:0] nv_cfg3l,
  input wire logic [7:0] nv_cfg3h,
  input wire logic [7:0] nv_cfg4l,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and decoded outputs
  input wire logic special_event_reset_enable,
  input wire logic capture_trigger,
  input wire logic stack_fault,
  input wire logic lvp_entry_request,
  input wire core_ctrl_t core_ctrl,
  input wire pin_ctrl_t pin_ctrl,
  input wire logic timebase_reset_pulse,
  input wire logic stack_reset_pulse,
  input wire logic lvp_entry_grant
);
  logic [1:0] cnt;
  logic [7:0] c3l, c3h, c4l;
  wire ok = cnt == 2'h3;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) cnt <= 2'h0;
    else if (!ok) cnt <= cnt + 2'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (cnt == 2'h0) {c3l, c3h, c4l} <= {nv_cfg3l, nv_cfg3h, nv_cfg4l};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  unmap_err_a: assert property (psel && penable && pready && paddr > ADDR_SWDT |-> pslverr && prdata == 0)
    else $error("unmapped access");
  tb_pulse_a: assert property (ok |-> timebase_reset_pulse == ($past(capture_trigger && special_event_reset_enable) && !c3l[5]))
    else $error("timebase pulse");
  stack_pulse_a: assert property (ok |-> stack_reset_pulse == ($past(stack_fault) && c4l[0]))
    else $error("stack pulse");
  lvp_grant_a: assert property (ok |-> lvp_entry_grant == ($past(lvp_entry_request) && c4l[2]))
    else $error("lvp grant");
  rst_pin_a: assert property (ok |-> core_ctrl.master_reset_active == c3h[7] && core_ctrl.port_e_bit3_input_en == !c3h[7])
    else $error("reset pin");
  pwm_en_a: assert property (ok |-> pin_ctrl.pwm_output_enable_field == (c3l[2] ? PWM_EN_OFF : PWM_EN_EIGHT))
    else $error("pwm enable");
  debug_own_a: assert property (ok |-> core_ctrl.debug_pins_owned == !c4l[7])
    else $error("debug pins");
  cfg_hold_a: assert property (ok && $past(ok) |-> $stable(core_ctrl.postscale_ratio) && $stable(pin_ctrl.block_protected))
    else $error("config moved");
  cover property (stack_reset_pulse);
  cover property (timebase_reset_pulse);
  cover property (pslverr);
endmodule
bind config_word_decoder config_word_checker chk_i (.*);

/* tb/config_word_decoder_tb.sv */
// Purpose: self-checking bench for the configuration word decoder
// Assumes: default parameters, eight outputs and large memory
// Notes: each word set is loaded through a reset
`timescale 1ns/1ns
module config_word_decoder_tb import cfg_word_pkg::*;;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] nv_cfg2h = 0, nv_cfg3l = 0, nv_cfg3h = 0, nv_cfg4l = 0, nv_cfg5l = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, pwm4_on_port_b5, timebase_reset_pulse, stack_reset_pulse, lvp_entry_grant;
  logic special_event_reset_enable = 0, capture_trigger = 0, stack_fault = 0, lvp_entry_request = 0;
  logic [7:0] pwm_raw = 0, pwm_fault_state = 0, pwm_override_state = 0, ssp_pin_sel, src;
  logic fault_active = 0, override_active = 0, port_c_bit1 = 0, port_c_bit3 = 0, port_d_bit0 = 0;
  logic port_d_bit4 = 0, ssp_sck_out = 0, ssp_sdo_out = 0;
  logic [2:0] port_c_ssp_out, port_d_ssp_out;
  core_ctrl_t core_ctrl;
  pin_ctrl_t pin_ctrl;
  logic [4:0][7:0] w;
  logic [7:0] mk [5] = '{MASK_CFG2H, MASK_CFG3L, MASK_CFG3H, MASK_CFG4L, MASK_CFG5L_LARGE};
  logic [63:0] r;
  int n_mismatch = 0, checks_done = 0, seed = 32'h138ED9F6;
  config_word_decoder dut (.*);
  always #2 ref_clk = ~ref_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge ref_clk);
  endtask
  task automatic load(logic [39:0] v);
    w = v;
    reset_n <= 1'b0;
    {nv_cfg5l, nv_cfg4l, nv_cfg3h, nv_cfg3l, nv_cfg2h} <= v;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic verify();
    chk("win", w[0][5], core_ctrl.window_enable);
    chk("ratio", 1 << w[0][4:1], core_ctrl.postscale_ratio);
    chk("wdrun", w[0][0], core_ctrl.watchdog_run);
    chk("dbg", !w[3][7], core_ctrl.debug_pins_owned);
    chk("lvp", w[3][2], core_ctrl.low_volt_prog_allowed);
    chk("stv", w[3][0], core_ctrl.stack_reset);
    chk("pen", w[1][2] ? 0 : 5, pin_ctrl.pwm_output_enable_field);
    chk("prot", {~w[4][3:0]}, pin_ctrl.block_protected);
    chk("ssp", w[2][2] ? 8'hB0 : 8'h0E, ssp_pin_sel);
    chk("pwm4", w[2][3], pwm4_on_port_b5);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 0);
      chk("cfg_rd", {24'h0, w[i] & mk[i]}, rd);
    end
    apb(1'b1, ADDR_CFG2H, 0);
    apb(1'b0, ADDR_CFG2H, 0);
    chk("ro_cfg", {24'h0, w[0] & mk[0]}, rd);
    apb(1'b0, 12'h01C, 0);
    chk("unmap_err", 1, er);
    chk("unmap_rd", 0, rd);
    apb(1'b1, ADDR_SWDT, 1);
    apb(1'b0, ADDR_STATUS, 0);
    chk("wd_soft", 32'h3, rd);
    chk("wd_run", 1, core_ctrl.watchdog_run);
    apb(1'b1, ADDR_SWDT, 0);
  endtask
  task automatic pins();
    for (int j = 0; j < 6; j++) begin
      r = {$random(seed), $random(seed)};
      {pwm_raw, pwm_fault_state, pwm_override_state, fault_active, override_active, port_c_bit1, port_c_bit3,
        port_d_bit0, port_d_bit4, special_event_reset_enable, capture_trigger, stack_fault, lvp_entry_request,
        ssp_sck_out, ssp_sdo_out} <= r[35:0];
      repeat (2) @(posedge ref_clk);
      src = override_active ? pwm_override_state : fault_active ? pwm_fault_state : pwm_raw;
      chk("pwm", {~(src ^ {4{w[1][4], w[1][3]}})}, pin_ctrl.pwm_pins);
      chk("tclk", w[2][4] ? port_c_bit3 : port_d_bit0, pin_ctrl.timer_ext_clock_in);
      chk("fault_a_input", w[2][0] ? port_c_bit1 : port_d_bit4, pin_ctrl.fault_a_input);
      chk("pc_ssp", w[2][2] ? {ssp_sdo_out, ssp_sck_out, 1'b0} : 3'h0, port_c_ssp_out);
      chk("pd_ssp", w[2][2] ? 3'h0 : {ssp_sck_out, 1'b0, ssp_sdo_out}, port_d_ssp_out);
      chk("tb_gate", !w[1][5] && special_event_reset_enable, core_ctrl.timebase_reset);
      chk("tb_pulse", !w[1][5] && special_event_reset_enable && capture_trigger, timebase_reset_pulse);
      chk("stk_pulse", w[3][0] && stack_fault, stack_reset_pulse);
      chk("lvp_grant", w[3][2] && lvp_entry_request, lvp_entry_grant);
      chk("rst_pin", {w[2][7], !w[2][7]}, {core_ctrl.master_reset_active, core_ctrl.port_e_bit3_input_en});
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 6; k++) begin
      r = {$random(seed), $random(seed)};
      load(k == 0 ? 40'hFFFFFFFFFF : k == 1 ? 40'h0 : r[39:0]);
      verify();
      pins();
      {nv_cfg5l, nv_cfg4l, nv_cfg3h, nv_cfg3l, nv_cfg2h} <= ~w;
      repeat (3) @(posedge ref_clk);
      verify();
      $display("test %0d done", k);
    end
    print_verdict();
  end
  initial begin
    #40000;
    n_mismatch++;
    print_verdict();
  end
endmodule
